//--- irq_wake_regs.svh
// Register offsets, bit positions, reset values and vectors of the interrupt and wake-up block
`ifndef IRQ_WAKE_REGS_SVH
`define IRQ_WAKE_REGS_SVH

// ==========================================================================
// Register byte offsets on the bus
`define IWR_OFF_MASK       8'h00
`define IWR_OFF_FLAG       8'h04
`define IWR_OFF_POWER      8'h08
`define IWR_OFF_WAKE       8'h0C
`define IWR_OFF_TIMER_CTL  8'h10
`define IWR_OFF_STATUS     8'h14

// ==========================================================================
// Source bit positions, shared by the flag and mask registers
`define IWR_BIT_TIMER      0
`define IWR_BIT_PIN_A      1
`define IWR_BIT_PIN_B      2
`define IWR_BIT_PIN_C      3
`define IWR_BIT_CNT1       4
`define IWR_BIT_CNT2       5
`define IWR_BIT_RESERVED   6
`define IWR_BIT_PIN_D      7

// Power mode register: bit 7 selects idle over sleep, bit 6 selects normal speed
`define IWR_BIT_PM_IDLE    7
`define IWR_BIT_PM_NORMAL  6

// Wake control register
`define IWR_BIT_WDT_EN     6
`define IWR_BIT_P9_HIGH    5
`define IWR_BIT_P9_LOW     4

// ==========================================================================
// Reset values and fetch addresses
`define IWR_RST_MASK       8'h00
`define IWR_RST_FLAG       8'h00
`define IWR_RST_POWER      8'h00
`define IWR_RST_WAKE       8'h00
`define IWR_RST_TIMER_CTL  8'hFF
`define IWR_VEC_RESET      12'h000
`define IWR_VEC_IRQ        12'h008

`endif

//--- irq_wake_pkg.sv
// Types shared by the interrupt, wake-up and reset control logic
package irq_wake_pkg;

	// Operating mode seen by the wake-up logic
	typedef enum logic [1:0] {
		MODE_NORMAL,
		MODE_GREEN,
		MODE_IDLE,
		MODE_SLEEP
	} power_mode_t;

	// Core run state as tracked by this block
	typedef enum logic {
		ST_RUN,
		ST_ASLEEP
	} core_state_t;

endpackage

//--- pin_sync_edge.sv
// Two-stage pin synchroniser with falling-edge and change detection
`timescale 1ns/1ps

module pin_sync_edge #(
	parameter int WIDTH = 4
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic [WIDTH-1:0] pin_i,
	output logic      [WIDTH-1:0] level_o,
	output logic      [WIDTH-1:0] fall_o,
	output logic      [WIDTH-1:0] change_o
);

	// ======================================================================
	// Elaboration check
	if (WIDTH < 1) begin : g_width_check
		$error("pin_sync_edge: WIDTH must be at least 1");
	end

	logic [WIDTH-1:0] meta;
	logic [WIDTH-1:0] stable;
	logic [WIDTH-1:0] prev;

	// Pins idle high: resetting to ones avoids a false edge after reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta   <= '1;
			stable <= '1;
			prev   <= '1;
		end else begin
			meta   <= pin_i;
			stable <= meta;   // Only the second stage reads the first
			prev   <= stable;
		end
	end

	// Edges are taken between the second and third stages only
	assign level_o  = stable;
	assign fall_o   = prev & ~stable;
	assign change_o = prev ^ stable;

endmodule

//--- interrupt_wakeup_reset_control.sv
// Interrupt, wake-up and reset control for the small 8-bit core
//
// The Wishbone slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "irq_wake_regs.svh"

// Summary of operation
// - Mask bits 0-5 and 7 enable their source; zero blocks it.
// - Falling edge on an enabled source sets its flag bit.
// - Enabled interrupt with global enable on vectors the core to 008H.
// - Only enable-interrupts sets global enable; disable-interrupts or any reset clears it.
// - Flag register holds captured requests for software to poll.
// - Masked port 7 pins are plain inputs and raise no interrupt.
// - Reset starts at 000H; hardware interrupts always use 008H.
// - Timer timeout vectors when running, resumes after sleep; flag set.
// - Idle mode: enabled timer or pin interrupt wakes and is taken.
// - Sleep mode ignores interrupts; port 9 change or watchdog resets.
// - Enabled watchdog resets in sleep, green, normal; port 9 ignored running.
// - Reset causes: power-on, watchdog, port 9 in sleep, reset pin low.
// - Reset clears counter, timers, watchdog enable and makes ports inputs.
// - Reset sets timer control to all ones, clears flags and mask.
module interrupt_wakeup_reset_control
	import irq_wake_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone classic slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// Interrupt, wake-up and reset sources
	input  wire logic        timer_ovf_i,
	input  wire logic        counter1_ovf_i,
	input  wire logic        counter2_ovf_i,
	input  wire logic [3:0]  port7_pin_i,
	input  wire logic [7:0]  port9_pin_i,
	input  wire logic        wdt_timeout_i,
	input  wire logic        reset_pin_n_i,
	// Core sequencer
	input  wire logic        instr_boundary_i,
	input  wire logic        enable_interrupts_instr_i,
	input  wire logic        disable_interrupts_instr_i,
	input  wire logic        sleep_instr_i,
	output logic             int_req_o,
	output logic             vector_fetch_o,
	output logic      [11:0] vector_addr_o,
	output logic             wake_o,
	output logic             core_asleep_o,
	output logic             sys_reset_o,
	output logic             wdt_enable_o,
	output logic             normal_speed_o,
	output logic      [7:0]  timer_prescaler_control_o,
	output logic             irq_o
);

	// ======================================================================
	// Pin synchronisers
	logic [3:0] p7_level;
	logic [3:0] p7_fall;
	logic [7:0] p9_change;
	logic       rst_pin_level;

	pin_sync_edge #(.WIDTH(4)) u_port7 (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.pin_i    (port7_pin_i),
		.level_o  (p7_level),
		.fall_o   (p7_fall),
		.change_o ()
	);

	pin_sync_edge #(.WIDTH(8)) u_port9 (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.pin_i    (port9_pin_i),
		.level_o  (),
		.fall_o   (),
		.change_o (p9_change)
	);

	pin_sync_edge #(.WIDTH(1)) u_rst_pin (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.pin_i    (reset_pin_n_i),
		.level_o  (rst_pin_level),
		.fall_o   (),
		.change_o ()
	);

	// ======================================================================
	// Register state
	logic [7:0]  interrupt_enable_mask;
	logic [7:0]  interrupt_flag_register;
	logic [7:0]  power_mode_register;
	logic [7:0]  wake_control;
	logic [7:0]  timer_prescaler_control;
	logic        global_enable;
	core_state_t state;
	logic        reset_hold;
	logic        ack;
	logic [31:0] rdata;
	logic        fetch;
	logic [11:0] vec_addr;
	logic        wake;
	logic [2:0]  int_prev;

	logic [7:0]  next_interrupt_enable_mask;
	logic [7:0]  next_interrupt_flag_register;
	logic [7:0]  next_power_mode_register;
	logic [7:0]  next_wake_control;
	logic [7:0]  next_timer_prescaler_control;
	logic        next_global_enable;
	core_state_t next_state;
	logic        next_reset_hold;
	logic        next_ack;
	logic [31:0] next_rdata;
	logic        next_fetch;
	logic [11:0] next_vec_addr;
	logic        next_wake;

	// Decode the mode from the power bits and whether the core sleeps
	function automatic power_mode_t decode_mode(input logic [7:0] pm, input core_state_t st);
		if (st == ST_ASLEEP)
			decode_mode = pm[`IWR_BIT_PM_IDLE] ? MODE_IDLE : MODE_SLEEP;
		else
			decode_mode = pm[`IWR_BIT_PM_NORMAL] ? MODE_NORMAL : MODE_GREEN;
	endfunction

	// ======================================================================
	// Event decode
	power_mode_t mode;
	logic [7:0]  src_fall;
	logic [7:0]  src_event;
	logic        p9_event;
	logic        wdt_event;
	logic        reset_cause;
	logic        bus_req;
	logic        wr_lane0;
	logic        take_irq;
	logic        clear;

	assign mode    = decode_mode(power_mode_register, state);
	assign clear   = rst_i | reset_hold;
	assign bus_req = cyc_i & stb_i & ~ack;
	assign wr_lane0 = bus_req & we_i & sel_i[0];

	// Internal sources are same-clock logic, only edge-detected here
	always_comb begin
		src_fall                    = 8'h00;
		src_fall[`IWR_BIT_TIMER]    = int_prev[0] & ~timer_ovf_i;
		src_fall[`IWR_BIT_CNT1]     = int_prev[1] & ~counter1_ovf_i;
		src_fall[`IWR_BIT_CNT2]     = int_prev[2] & ~counter2_ovf_i;
		src_fall[`IWR_BIT_PIN_A]    = p7_fall[0];
		src_fall[`IWR_BIT_PIN_B]    = p7_fall[1];
		src_fall[`IWR_BIT_PIN_C]    = p7_fall[2];
		src_fall[`IWR_BIT_PIN_D]    = p7_fall[3];
	end

	// Masked pins never reach the flags; sleep mode ignores every source
	assign src_event = (mode == MODE_SLEEP) ? 8'h00 : (src_fall & interrupt_enable_mask);

	assign p9_event = ((|p9_change[7:4]) & wake_control[`IWR_BIT_P9_HIGH]) |
		((|p9_change[3:0]) & wake_control[`IWR_BIT_P9_LOW]);
	assign wdt_event = wdt_timeout_i & wake_control[`IWR_BIT_WDT_EN];

	// Idle turns the watchdog and port 9 into plain wake-ups
	assign reset_cause = ~rst_pin_level |
		((mode == MODE_SLEEP) & p9_event) |
		(wdt_event & (mode != MODE_IDLE));

	assign irq_o     = |(interrupt_flag_register & interrupt_enable_mask);
	assign int_req_o = irq_o & global_enable & (state == ST_RUN);
	assign take_irq  = int_req_o & instr_boundary_i;

	// ======================================================================
	// Next-state logic
	always_comb begin
		next_interrupt_enable_mask   = interrupt_enable_mask;
		next_interrupt_flag_register = interrupt_flag_register;
		next_power_mode_register     = power_mode_register;
		next_wake_control            = wake_control;
		next_timer_prescaler_control = timer_prescaler_control;
		next_global_enable           = global_enable;
		next_state                   = state;
		next_reset_hold              = reset_cause;
		next_ack                     = bus_req;
		next_rdata                   = 32'h0000_0000;
		next_fetch                   = 1'b0;
		next_vec_addr                = vec_addr;
		next_wake                    = 1'b0;

		// Register writes; only byte lane 0 carries data
		if (wr_lane0) begin
			unique case (adr_i)
				`IWR_OFF_MASK: begin
					next_interrupt_enable_mask = dat_i[7:0];
					next_interrupt_enable_mask[`IWR_BIT_RESERVED] = 1'b0;
				end
				`IWR_OFF_FLAG:
					next_interrupt_flag_register = interrupt_flag_register & ~dat_i[7:0];
				`IWR_OFF_POWER:
					next_power_mode_register = {dat_i[7:6], 6'h00};
				`IWR_OFF_WAKE:
					next_wake_control = {1'b0, dat_i[6:4], 4'h0};
				`IWR_OFF_TIMER_CTL:
					next_timer_prescaler_control = dat_i[7:0];
				default: begin
				end
			endcase
		end

		// Reads; unmapped offsets answer zero
		if (bus_req && !we_i) begin
			unique case (adr_i)
				`IWR_OFF_MASK:      next_rdata = {24'h000000, interrupt_enable_mask};
				`IWR_OFF_FLAG:      next_rdata = {24'h000000, interrupt_flag_register};
				`IWR_OFF_POWER:     next_rdata = {24'h000000, power_mode_register};
				`IWR_OFF_WAKE:      next_rdata = {24'h000000, wake_control};
				`IWR_OFF_TIMER_CTL: next_rdata = {24'h000000, timer_prescaler_control};
				`IWR_OFF_STATUS:    next_rdata = {28'h0000000, mode, state == ST_ASLEEP, global_enable};
				default:            next_rdata = 32'h0000_0000;
			endcase
		end

		// A new edge wins over a clear in the same cycle
		next_interrupt_flag_register = next_interrupt_flag_register | src_event;

		// Global enable changes only on the two instructions and on any reset
		if (enable_interrupts_instr_i && !disable_interrupts_instr_i)
			next_global_enable = 1'b1;
		else if (disable_interrupts_instr_i)
			next_global_enable = 1'b0;

		// Hardware interrupts always use the fixed vector
		if (take_irq) begin
			next_fetch    = 1'b1;
			next_vec_addr = `IWR_VEC_IRQ;
		end

		// Sleep and wake; only a reset leaves sleep mode
		unique case (state)
			ST_RUN:
				if (sleep_instr_i)
					next_state = ST_ASLEEP;
			ST_ASLEEP:
				if (mode == MODE_IDLE && ((|src_event) || p9_event || wdt_event)) begin
					next_state = ST_RUN;
					next_wake  = 1'b1;
				end
		endcase

		// Any reset source returns the block to its defaults
		if (clear) begin
			next_interrupt_enable_mask   = `IWR_RST_MASK;
			next_interrupt_flag_register = `IWR_RST_FLAG;
			next_power_mode_register     = `IWR_RST_POWER;
			next_wake_control            = `IWR_RST_WAKE;
			next_timer_prescaler_control = `IWR_RST_TIMER_CTL;
			next_global_enable           = 1'b0;
			next_state                   = ST_RUN;
			next_fetch                   = 1'b0;
			next_vec_addr                = `IWR_VEC_RESET;
			next_wake                    = 1'b0;
		end
		if (rst_i) begin
			next_reset_hold = 1'b1;
			next_ack        = 1'b0;
		end
	end

	// ======================================================================
	// State registers
	always_ff @(posedge clk_i) begin
		interrupt_enable_mask   <= next_interrupt_enable_mask;
		interrupt_flag_register <= next_interrupt_flag_register;
		power_mode_register     <= next_power_mode_register;
		wake_control            <= next_wake_control;
		timer_prescaler_control <= next_timer_prescaler_control;
		global_enable           <= next_global_enable;
		state                   <= next_state;
		reset_hold              <= next_reset_hold;
		ack                     <= next_ack;
		rdata                   <= next_rdata;
		fetch                   <= next_fetch;
		vec_addr                <= next_vec_addr;
		wake                    <= next_wake;
		int_prev                <= rst_i ? 3'h0 : {counter2_ovf_i, counter1_ovf_i, timer_ovf_i};
	end

	// The reset pulse clears program counter, timers and port directions outside
	assign sys_reset_o               = reset_hold;
	assign ack_o                     = ack;
	assign dat_o                     = rdata;
	assign vector_fetch_o            = fetch;
	assign vector_addr_o             = vec_addr;
	assign wake_o                    = wake;
	assign core_asleep_o             = (state == ST_ASLEEP);
	assign wdt_enable_o              = wake_control[`IWR_BIT_WDT_EN];
	assign normal_speed_o            = power_mode_register[`IWR_BIT_PM_NORMAL];
	assign timer_prescaler_control_o = timer_prescaler_control;

	// ======================================================================
	// Assertions
	AST_MASK_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_lane0 && adr_i == `IWR_OFF_MASK && !reset_hold) |=>
		interrupt_enable_mask == {$past(dat_i[7]), 1'b0, $past(dat_i[5:0])})
		else $error("Mask register did not take the written enables");

	AST_FLAG_SET: assert property (@(posedge clk_i) disable iff (rst_i)
		(|src_event && !reset_hold) |=> ((interrupt_flag_register & $past(src_event)) == $past(src_event)))
		else $error("Source edge did not set its flag");

	AST_VECTOR: assert property (@(posedge clk_i) disable iff (rst_i)
		(take_irq && !reset_hold) |=> (vector_fetch_o && vector_addr_o == `IWR_VEC_IRQ))
		else $error("Interrupt not vectored to its fixed address");

	AST_GIE_ON: assert property (@(posedge clk_i) disable iff (rst_i)
		(enable_interrupts_instr_i && !disable_interrupts_instr_i && !reset_hold) |=> global_enable ##1
		(global_enable || $past(disable_interrupts_instr_i) || $past(reset_hold)))
		else $error("Global enable not held after enable instruction");

	AST_SLEEP_IGNORE: assert property (@(posedge clk_i) disable iff (rst_i)
		(mode == MODE_SLEEP && !wr_lane0 && !reset_hold) |=> $stable(interrupt_flag_register))
		else $error("Flag changed in sleep mode");

	AST_RESET_CAUSE: assert property (@(posedge clk_i) disable iff (rst_i)
		reset_cause |=> sys_reset_o)
		else $error("Reset cause did not raise the system reset");

	AST_RESET_DEFAULTS: assert property (@(posedge clk_i)
		sys_reset_o |=> (interrupt_enable_mask == `IWR_RST_MASK && interrupt_flag_register == `IWR_RST_FLAG &&
		timer_prescaler_control == `IWR_RST_TIMER_CTL && vector_addr_o == `IWR_VEC_RESET && !wdt_enable_o))
		else $error("Reset defaults not applied");

	AST_IDLE_WAKE: assert property (@(posedge clk_i) disable iff (rst_i)
		(mode == MODE_IDLE && |src_event && !reset_cause && !reset_hold) |=>
		(wake_o && !core_asleep_o) ##1 !wake_o)
		else $error("Idle interrupt did not wake the core");

	AST_REQUEST: assert property (@(posedge clk_i) disable iff (rst_i)
		int_req_o |-> (global_enable && |(interrupt_flag_register & interrupt_enable_mask)))
		else $error("Request without enabled pending flag");

	AST_BUS_ACK: assert property (@(posedge clk_i) disable iff (rst_i)
		(cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o)
		else $error("Bus acknowledge not a single cycle");

endmodule

//--- core_model.sv
// Behavioural core sequencer that offers instruction boundaries and counts vector fetches
`timescale 1ns/1ps

module core_model (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       slow_i,
	input  wire logic       asleep_i,
	input  wire logic       vector_fetch_i,
	output logic            boundary_o,
	output logic      [7:0] fetch_count_o
);
	logic [1:0] phase;

	// ==========================================================================
	// Boundaries: a slow core spends four cycles an instruction, a stopped core offers none
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			phase <= 2'h0;
			boundary_o <= 1'b0;
			fetch_count_o <= 8'h00;
		end else begin
			phase <= phase + 2'h1;
			boundary_o <= !asleep_i && (!slow_i || phase == 2'h3);
			if (vector_fetch_i) begin
				fetch_count_o <= fetch_count_o + 8'h01;
			end
		end
	end
endmodule

//--- test_interrupt_wakeup_reset_control.sv
// Self-checking bench for the interrupt, wake-up and reset control block
`timescale 1ns/1ps
`include "irq_wake_regs.svh"

module test_interrupt_wakeup_reset_control;
	import irq_wake_pkg::*;

	typedef struct {
		logic [7:0] mask;
		int         src;
		logic [7:0] flag;
	} row_t;

	logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq_o, int_req_o;
	logic [7:0]  adr_i, port9_pin_i, timer_prescaler_control_o, q, fetch_count;
	logic [3:0]  sel_i, port7_pin_i;
	logic [31:0] dat_i, dat_o;
	logic        timer_ovf_i, counter1_ovf_i, counter2_ovf_i, wdt_timeout_i, reset_pin_n_i;
	logic        instr_boundary_i, enable_interrupts_instr_i, disable_interrupts_instr_i, sleep_instr_i;
	logic        vector_fetch_o, wake_o, core_asleep_o, sys_reset_o, wdt_enable_o, normal_speed_o;
	logic [11:0] vector_addr_o;
	logic        slow, seen_rst, seen_wake, seen_fetch;
	int          n_errors, tests_run;
	int          n_rst_seen, n_wake_seen, n_fetch_seen, rst_mark, wake_mark, fetch_mark;

	// Ordinary cases: mask setting, source fired, flag expected
	row_t rows[10] = '{'{8'h01, 0, 8'h01}, '{8'hFE, 0, 8'h00}, '{8'h02, 1, 8'h02}, '{8'h04, 2, 8'h04},
		'{8'h08, 3, 8'h08}, '{8'h10, 4, 8'h10}, '{8'h20, 5, 8'h20}, '{8'h80, 7, 8'h80},
		'{8'h7F, 7, 8'h00}, '{8'hFD, 1, 8'h00}};

	interrupt_wakeup_reset_control DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
		.we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.timer_ovf_i(timer_ovf_i), .counter1_ovf_i(counter1_ovf_i), .counter2_ovf_i(counter2_ovf_i),
		.port7_pin_i(port7_pin_i), .port9_pin_i(port9_pin_i), .wdt_timeout_i(wdt_timeout_i),
		.reset_pin_n_i(reset_pin_n_i), .instr_boundary_i(instr_boundary_i),
		.enable_interrupts_instr_i(enable_interrupts_instr_i),
		.disable_interrupts_instr_i(disable_interrupts_instr_i), .sleep_instr_i(sleep_instr_i),
		.int_req_o(int_req_o), .vector_fetch_o(vector_fetch_o), .vector_addr_o(vector_addr_o),
		.wake_o(wake_o), .core_asleep_o(core_asleep_o), .sys_reset_o(sys_reset_o),
		.wdt_enable_o(wdt_enable_o), .normal_speed_o(normal_speed_o),
		.timer_prescaler_control_o(timer_prescaler_control_o), .irq_o(irq_o));

	core_model core (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .asleep_i(core_asleep_o),
		.vector_fetch_i(vector_fetch_o), .boundary_o(instr_boundary_i), .fetch_count_o(fetch_count));

	// ==========================================================================
	// Clock and one-cycle pulse catchers, so short pulses are never missed
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	// Pulses are counted here only; each test compares against its own start mark
	always @(posedge clk_i) begin
		if (sys_reset_o === 1'b1) n_rst_seen <= n_rst_seen + 1;
		if (wake_o === 1'b1) n_wake_seen <= n_wake_seen + 1;
		if (vector_fetch_o === 1'b1) n_fetch_seen <= n_fetch_seen + 1;
	end

	assign seen_rst   = (n_rst_seen != rst_mark);
	assign seen_wake  = (n_wake_seen != wake_mark);
	assign seen_fetch = (n_fetch_seen != fetch_mark);

	// ==========================================================================
	// Shared tasks
	task tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	task chk(input logic [11:0] got, input logic [11:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Classic cycle: hold everything until ack is sampled, then release for a cycle
	// No local limit: only the watchdog below may end a wait
	task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= {24'h000000, d};
		sel_i <= 4'hF;
		do begin
			tick(1);
		end while (ack_o !== 1'b1);
		q = dat_o[7:0];
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
		tick(1);
	endtask

	// Rise then fall of one source; pins idle high and only fall
	task fire(input int k);
		int p;
		p = (k == 7) ? 3 : k - 1;
		timer_ovf_i <= (k == 0);
		counter1_ovf_i <= (k == 4);
		counter2_ovf_i <= (k == 5);
		tick(2);
		timer_ovf_i <= 1'b0;
		counter1_ovf_i <= 1'b0;
		counter2_ovf_i <= 1'b0;
		if (k inside {1, 2, 3, 7}) port7_pin_i[p] <= 1'b0;
		tick(6);
		port7_pin_i <= 4'hF;
		tick(6);
	endtask

	task pulse_sleep();
		sleep_instr_i <= 1'b1;
		tick(1);
		sleep_instr_i <= 1'b0;
		tick(3);
	endtask

	task done(input string s);
		$display("test %s finished", s);
		rst_mark = n_rst_seen;
		wake_mark = n_wake_seen;
		fetch_mark = n_fetch_seen;
	endtask

	task end_sim();
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Watchdog well beyond the few hundred cycles the sequence needs
	initial begin
		#160000;
		n_errors++;
		end_sim();
	end

	// ==========================================================================
	// Main sequence
	initial begin
		{cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = '0;
		{timer_ovf_i, counter1_ovf_i, counter2_ovf_i, wdt_timeout_i, port9_pin_i} = '0;
		{enable_interrupts_instr_i, disable_interrupts_instr_i, sleep_instr_i, slow} = '0;
		port7_pin_i = 4'hF;
		reset_pin_n_i = 1'b1;
		n_errors = 0;
		tests_run = 0;
		rst_i = 1'b1;
		tick(16);
		rst_i <= 1'b0;
		tick(4);
		done("reset");
		wb(0, `IWR_OFF_MASK, 8'h00); chk(q, 8'h00);
		wb(0, `IWR_OFF_FLAG, 8'h00); chk(q, 8'h00);
		wb(0, `IWR_OFF_TIMER_CTL, 8'h00); chk(q, 8'hFF);
		chk(timer_prescaler_control_o, 8'hFF);
		chk(wdt_enable_o, 1'b0);
		chk(vector_addr_o, 12'h000);
		wb(0, 8'h40, 8'h00); chk(q, 8'h00);
		wb(1, `IWR_OFF_MASK, 8'hFF);
		wb(0, `IWR_OFF_MASK, 8'h00); chk(q, 8'hBF);
		done("defaults");
		for (int i = 0; i < 10; i++) begin
			wb(1, `IWR_OFF_MASK, rows[i].mask);
			fire(rows[i].src);
			wb(0, `IWR_OFF_FLAG, 8'h00); chk(q, rows[i].flag);
			chk(irq_o, |rows[i].flag);
			wb(1, `IWR_OFF_FLAG, 8'hFF);
			wb(0, `IWR_OFF_FLAG, 8'h00); chk(q, 8'h00);
		end
		done("sources");
		// Slow core so the take waits for a later boundary
		slow <= 1'b1;
		wb(1, `IWR_OFF_MASK, 8'h01);
		fire(0);
		chk(int_req_o, 1'b0);
		chk(seen_fetch, 1'b0);
		enable_interrupts_instr_i <= 1'b1;
		tick(1);
		enable_interrupts_instr_i <= 1'b0;
		tick(12);
		chk(int_req_o, 1'b1);
		chk(seen_fetch, 1'b1);
		chk(fetch_count != 8'h00, 1'b1);
		chk(vector_addr_o, 12'h008);
		disable_interrupts_instr_i <= 1'b1;
		tick(1);
		disable_interrupts_instr_i <= 1'b0;
		tick(2);
		chk(int_req_o, 1'b0);
		chk(irq_o, 1'b1);
		wb(1, `IWR_OFF_FLAG, 8'h01);
		tick(1);
		chk(irq_o, 1'b0);
		done("take");
		wb(1, `IWR_OFF_POWER, 8'h80);
		pulse_sleep();
		chk(core_asleep_o, 1'b1);
		// Status: idle mode code 2, asleep, global enable off
		wb(0, `IWR_OFF_STATUS, 8'h00); chk(q, 8'h0A);
		fire(0);
		chk(seen_wake, 1'b1);
		chk(core_asleep_o, 1'b0);
		wb(0, `IWR_OFF_FLAG, 8'h00); chk(q, 8'h01);
		wb(1, `IWR_OFF_FLAG, 8'h01);
		done("idle");
		// Idle: a port 9 change wakes the core with no reset and no flag
		wb(1, `IWR_OFF_WAKE, 8'h10);
		pulse_sleep();
		port9_pin_i[0] <= 1'b1;
		tick(8);
		chk(seen_wake, 1'b1);
		chk(seen_rst, 1'b0);
		chk(core_asleep_o, 1'b0);
		wb(0, `IWR_OFF_FLAG, 8'h00); chk(q, 8'h00);
		done("idle port");
		wb(1, `IWR_OFF_WAKE, 8'h10);
		wb(1, `IWR_OFF_POWER, 8'h00);
		pulse_sleep();
		fire(0);
		chk(core_asleep_o, 1'b1);
		wb(0, `IWR_OFF_FLAG, 8'h00); chk(q, 8'h00);
		chk(seen_rst, 1'b0);
		port9_pin_i[0] <= 1'b0;
		tick(8);
		chk(seen_rst, 1'b1);
		wb(0, `IWR_OFF_MASK, 8'h00); chk(q, 8'h00);
		done("sleep");
		wb(1, `IWR_OFF_TIMER_CTL, 8'h00);
		wb(1, `IWR_OFF_WAKE, 8'h70);
		wb(1, `IWR_OFF_POWER, 8'h40);
		tick(1);
		chk(wdt_enable_o, 1'b1);
		chk(normal_speed_o, 1'b1);
		port9_pin_i <= 8'hF0;
		tick(8);
		chk(seen_rst, 1'b0);
		wdt_timeout_i <= 1'b1;
		tick(1);
		wdt_timeout_i <= 1'b0;
		tick(6);
		chk(seen_rst, 1'b1);
		chk(wdt_enable_o, 1'b0);
		chk(timer_prescaler_control_o, 8'hFF);
		done("watchdog");
		reset_pin_n_i <= 1'b0;
		tick(4);
		reset_pin_n_i <= 1'b1;
		tick(8);
		chk(seen_rst, 1'b1);
		chk(vector_addr_o, 12'h000);
		done("reset pin");
		end_sim();
	end
endmodule
